// ### hw/pv_mode_ctrl.sv
// Profile-velocity mode control: command decode, setpoint, ramp and status
`timescale 1ns/100ps
module pv_mode_ctrl
  import pv_mode_pkg::*;
#(
  parameter int unsigned CLK_RATE_HZ = CLK_HZ
) (
  input  wire logic               CORE_CLK_I,
  input  wire logic               RST_I,
  input  wire logic               PDO_VALID_I,
  input  wire rx_pdo_s            RX_PDO_I,
  input  wire logic signed [31:0] ACT_SPEED_I,
  input  wire logic               FAULT_I,
  input  wire logic [31:0]        MAX_SPEED_I,
  input  wire logic [31:0]        RAMP_CEIL_I,
  input  wire logic               PAR_WE_I,
  input  wire logic               PAR_RE_I,
  input  wire logic [15:0]        PAR_ADDR_I,
  input  wire logic [31:0]        PAR_WDATA_I,
  output logic [31:0]             PAR_RDATA_O,
  output logic                    PAR_ACK_O,
  output tx_pdo_s                 TX_PDO_O,
  output logic                    TX_VALID_O,
  output logic signed [31:0]      SPEED_REF_O,
  output logic                    POWER_EN_O
);
  drive_state_e       state_reg;
  drive_state_e       state_next;
  logic [7:0]         req_mode_reg;
  logic [7:0]         req_mode_next;
  logic [7:0]         act_mode_reg;
  logic [7:0]         act_mode_next;
  logic signed [31:0] tgt_reg;
  logic signed [31:0] tgt_next;
  logic [31:0]        accel_reg;
  logic [31:0]        decel_reg;
  logic [15:0]        cmd_reg;
  logic               no_cmd_reg;
  logic               no_cmd_next;
  logic [15:0]        status_next;
  logic [15:0]        status_reg;
  logic [7:0]         mode_rb_reg;
  logic               tx_valid_reg;
  logic [31:0]        rdata_reg;
  logic               ack_reg;
  logic               power_reg;
  logic signed [31:0] lim_tgt;
  logic signed [31:0] ramp_speed;

  // Mode-specific command bits are reserved here and dropped before decode
  wire logic [15:0] cw_w = RX_PDO_I.cmd & ~CW_MODE_MASK;
  wire logic cmd_off_w   = !cw_w[CW_VOLTAGE];
  wire logic cmd_qs_w    = cw_w[CW_VOLTAGE] && !cw_w[CW_QSTOP_N];
  wire logic cmd_shut_w  = cw_w[CW_VOLTAGE] && cw_w[CW_QSTOP_N] && !cw_w[CW_SWITCH_ON];
  wire logic cmd_on_w    = cw_w[CW_VOLTAGE] && cw_w[CW_QSTOP_N] && cw_w[CW_SWITCH_ON]
                           && cw_w[CW_ENABLE_OP];
  wire logic cmd_frst_w  = cw_w[CW_FAULT_RST];
  wire logic halt_w      = cmd_reg[CW_HALT];

  wire logic ref_zero_w  = ramp_speed == 0;
  wire logic act_zero_w  = ACT_SPEED_I == 0;
  wire logic standstill_w = ref_zero_w && act_zero_w;
  wire logic pv_active_w = act_mode_reg == MODE_PROFILE_VEL;
  wire logic pdo_take_w  = PDO_VALID_I;
  wire logic par_wr_tgt_w = PAR_WE_I && (PAR_ADDR_I == REG_TARGET_SPEED);
  wire logic tgt_write_w = pdo_take_w || par_wr_tgt_w;

  // Drive state machine, advanced on each received command word
  always_comb begin
    state_next = state_reg;
    if (FAULT_I) begin
      state_next = ST_FAULT;
    end else if (pdo_take_w) begin
      unique case (state_reg)
        ST_DISABLED: begin
          if (cmd_shut_w) begin
            state_next = ST_READY;
          end
        end
        ST_READY: begin
          if (cmd_off_w) begin
            state_next = ST_DISABLED;
          end else if (cmd_on_w) begin
            state_next = ST_ENABLED;
          end
        end
        ST_ENABLED: begin
          if (cmd_off_w) begin
            state_next = ST_DISABLED;
          end else if (cmd_qs_w) begin
            state_next = ST_QSTOP;
          end else if (cmd_shut_w) begin
            state_next = ST_READY;
          end
        end
        ST_QSTOP: begin
          // Re-enable only once the ramp has brought the speed reference to zero
          if (cmd_off_w) begin
            state_next = ST_DISABLED;
          end else if (cmd_on_w && ref_zero_w) begin
            state_next = ST_ENABLED;
          end
        end
        ST_FAULT: begin
          if (cmd_frst_w) begin
            state_next = ST_DISABLED;
          end
        end
        default: begin
          state_next = ST_FAULT;
        end
      endcase
    end
  end

  // Mode switches at once unless leaving profile velocity while still turning
  assign req_mode_next = pdo_take_w ? RX_PDO_I.mode : req_mode_reg;
  assign act_mode_next = (!pv_active_w || standstill_w) ? req_mode_next : act_mode_reg;

  // Receive image wins over a parameter write in the same cycle
  assign tgt_next = pdo_take_w ? RX_PDO_I.target : par_wr_tgt_w ? $signed(PAR_WDATA_I)
                    : tgt_reg;

  // Flag cleared by the first setpoint write while the mode is active
  assign no_cmd_next = (state_reg != ST_ENABLED && state_next == ST_ENABLED) ? 1'b1
                       : (tgt_write_w && pv_active_w) ? 1'b0 : no_cmd_reg;

  speed_limiter u_limiter (
    .speed_i     (tgt_reg),
    .max_speed_i (MAX_SPEED_I),
    .ramp_ceil_i (RAMP_CEIL_I),
    .speed_o     (lim_tgt)
  );

  // Halt, quick stop, fault or another mode all ramp the profile to zero
  wire logic run_w = state_reg == ST_ENABLED && pv_active_w && !halt_w && !no_cmd_reg
                     && req_mode_reg == MODE_PROFILE_VEL;
  wire logic signed [31:0] ramp_tgt_w = run_w ? lim_tgt : '0;

  speed_ramp #(
    .CLK_RATE_HZ (CLK_RATE_HZ)
  ) u_ramp (
    .clk_i    (CORE_CLK_I),
    .rst_i    (RST_I),
    .target_i (ramp_tgt_w),
    .accel_i  (accel_reg),
    .decel_i  (decel_reg),
    .speed_o  (ramp_speed)
  );

  wire logic reached_w = ACT_SPEED_I == ramp_tgt_w;
  wire logic [15:0] base_w = (state_reg == ST_ENABLED) ? STW_ENABLED
                           : (state_reg == ST_READY)   ? STW_READY
                           : (state_reg == ST_QSTOP)   ? STW_QSTOP
                           : (state_reg == ST_FAULT)   ? STW_FAULT : STW_SW_DISABLED;
  always_comb begin
    status_next = base_w;
    status_next[STW_REACHED] = reached_w;
    status_next[STW_ZERO]    = pv_active_w && act_zero_w;
    status_next[STW_NO_CMD]  = state_reg == ST_ENABLED && no_cmd_reg;
  end

  wire logic [31:0] rd_mux_w = (PAR_ADDR_I == REG_TARGET_SPEED) ? tgt_reg : '0;
  wire logic power_next_w = state_reg == ST_ENABLED || state_reg == ST_QSTOP
                            || (state_reg == ST_FAULT && !ref_zero_w);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_reg    <= ST_DISABLED;
      req_mode_reg <= MODE_RESET;
      act_mode_reg <= MODE_RESET;
      tgt_reg      <= TARGET_RESET;
      accel_reg    <= '0;
      decel_reg    <= '0;
      cmd_reg      <= '0;
      no_cmd_reg   <= 1'b1;
    end else begin
      state_reg    <= state_next;
      req_mode_reg <= req_mode_next;
      act_mode_reg <= act_mode_next;
      tgt_reg      <= tgt_next;
      no_cmd_reg   <= no_cmd_next;
      if (pdo_take_w) begin
        accel_reg <= RX_PDO_I.accel;
        decel_reg <= RX_PDO_I.decel;
        cmd_reg   <= cw_w;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      status_reg   <= STW_SW_DISABLED;
      mode_rb_reg  <= MODE_RESET;
      tx_valid_reg <= 1'b0;
      rdata_reg    <= '0;
      ack_reg      <= 1'b0;
      power_reg    <= 1'b0;
    end else begin
      status_reg   <= status_next;
      mode_rb_reg  <= act_mode_reg;
      tx_valid_reg <= pdo_take_w;
      rdata_reg    <= PAR_RE_I ? rd_mux_w : '0;
      ack_reg      <= PAR_RE_I || PAR_WE_I;
      power_reg    <= power_next_w;
    end
  end

  assign TX_PDO_O.status = status_reg;
  assign TX_PDO_O.mode   = mode_rb_reg;
  assign TX_VALID_O      = tx_valid_reg;
  assign PAR_RDATA_O     = rdata_reg;
  assign PAR_ACK_O       = ack_reg;
  assign SPEED_REF_O     = ramp_speed;
  assign POWER_EN_O      = power_reg;

  // Checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  sequence pv_select_s;
    PDO_VALID_I && RX_PDO_I.mode == MODE_PROFILE_VEL && !pv_active_w && !FAULT_I;
  endsequence
  sequence qstop_cmd_s;
    PDO_VALID_I && !FAULT_I && state_reg == ST_ENABLED
      && (RX_PDO_I.cmd & ~CW_MODE_MASK) == CW_QUICKSTOP;
  endsequence
  sequence enable_cmd_s;
    PDO_VALID_I && !FAULT_I && state_reg == ST_READY
      && (RX_PDO_I.cmd & ~CW_MODE_MASK) == CW_ENABLE;
  endsequence
  sequence enable_entry_s;
    state_reg != ST_ENABLED && state_next == ST_ENABLED;
  endsequence

  mode_readback_a: assert property (
    pv_select_s |-> ##2 TX_PDO_O.mode == MODE_PROFILE_VEL)
    else $error("mode readback did not follow write");

  reached_bit_a: assert property (
    reached_w |=> TX_PDO_O.status[STW_REACHED] == 1'b1)
    else $error("reached bit not set");

  zero_bit_a: assert property (
    pv_active_w |=> TX_PDO_O.status[STW_ZERO] == $past(act_zero_w))
    else $error("standstill bit wrong");

  mode_hold_a: assert property (
    pv_active_w && !ref_zero_w |=> pv_active_w)
    else $error("mode left while moving");

  clamp_ceiling_a: assert property (
    mag32(lim_tgt) <= MAX_SPEED_I && mag32(lim_tgt) <= RAMP_CEIL_I)
    else $error("limited setpoint above ceiling");

  setpoint_now_a: assert property (
    PDO_VALID_I |=> tgt_reg == $past(RX_PDO_I.target))
    else $error("setpoint not taken at once");

  enable_word_a: assert property (
    enable_cmd_s ##1 (!pv_active_w && act_zero_w && !FAULT_I)
      |=> TX_PDO_O.status == STW_ENABLED_NEW)
    else $error("enabled word wrong");

  reached_word_a: assert property (
    state_reg == ST_ENABLED && !no_cmd_reg && reached_w && !act_zero_w
      |=> TX_PDO_O.status == STW_ENABLED_AT)
    else $error("running word wrong");

  qstop_entry_a: assert property (
    qstop_cmd_s |=> state_reg == ST_QSTOP ##1 TX_PDO_O.status[STW_QS_N] == 1'b0)
    else $error("quick stop not entered");

  qstop_decel_a: assert property (
    state_reg == ST_QSTOP |=> mag32(SPEED_REF_O) <= $past(mag32(SPEED_REF_O)))
    else $error("speed grew during quick stop");

  ramp_step_a: assert property (
    ##1 mag32(32'(SPEED_REF_O - $past(SPEED_REF_O))) <= 32'h0000_0001)
    else $error("speed stepped by more than one");

  tx_each_cycle_a: assert property (
    PDO_VALID_I |=> TX_VALID_O)
    else $error("no transmit image answered");

  par_ack_a: assert property (
    PAR_WE_I || PAR_RE_I |=> PAR_ACK_O)
    else $error("parameter access not acknowledged");

  setpoint_read_a: assert property (
    PAR_RE_I && PAR_ADDR_I == REG_TARGET_SPEED |=> PAR_RDATA_O == $past(tgt_reg))
    else $error("setpoint read data wrong");

  setpoint_write_a: assert property (
    PAR_WE_I && PAR_ADDR_I == REG_TARGET_SPEED && !PDO_VALID_I
      |=> tgt_reg == $past(PAR_WDATA_I))
    else $error("setpoint write not taken");

  start_move_a: assert property (
    state_reg == ST_ENABLED && state_next == ST_ENABLED && pv_active_w && tgt_write_w
      |=> !no_cmd_reg)
    else $error("setpoint write did not start movement");

  enable_flag_a: assert property (
    enable_entry_s |-> ##2 TX_PDO_O.status[STW_NO_CMD])
    else $error("no-setpoint flag missing after enable");

  qstop_resume_a: assert property (
    state_reg == ST_QSTOP && PDO_VALID_I && !FAULT_I && cmd_on_w && ref_zero_w
      |=> state_reg == ST_ENABLED)
    else $error("quick stop not cleared");

  qstop_wait_a: assert property (
    state_reg == ST_QSTOP && !ref_zero_w && !FAULT_I && !(PDO_VALID_I && cmd_off_w)
      |=> state_reg == ST_QSTOP)
    else $error("quick stop left while moving");

  fault_entry_a: assert property (
    FAULT_I |=> state_reg == ST_FAULT)
    else $error("fault not entered");

  power_stage_a: assert property (
    state_reg == ST_ENABLED |=> POWER_EN_O)
    else $error("power stage off while enabled");

  rx_accept_a: assert property (
    PDO_VALID_I |=> accel_reg == $past(RX_PDO_I.accel) && decel_reg == $past(RX_PDO_I.decel)
      && req_mode_reg == $past(RX_PDO_I.mode))
    else $error("receive image fields not taken");

  stop_ramp_a: assert property (
    !run_w |=> mag32(SPEED_REF_O) <= $past(mag32(SPEED_REF_O)))
    else $error("speed grew while stopping");

  mode_defer_a: assert property (
    pv_active_w && !act_zero_w |=> pv_active_w)
    else $error("mode left while motor turns");
endmodule

// ### hw/pv_mode_pkg.sv
// Shared constants, types and helpers for the profile-velocity mode logic
package pv_mode_pkg;
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam logic [7:0]  MODE_PROFILE_VEL = 8'h03;
  localparam logic [15:0] REG_TARGET_SPEED = 16'h1B1A;
  localparam logic [31:0] TARGET_RESET     = 32'h0000_0000;
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  // Command word bit positions
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_VOLTAGE   = 1;
  localparam int CW_QSTOP_N   = 2;
  localparam int CW_ENABLE_OP = 3;
  localparam int CW_FAULT_RST = 7;
  localparam int CW_HALT      = 8;
  localparam logic [15:0] CW_MODE_MASK = 16'h0070;
  localparam logic [15:0] CW_ENABLE    = 16'h000F;
  localparam logic [15:0] CW_QUICKSTOP = 16'h000B;
  // Status word images per drive state
  localparam logic [15:0] STW_SW_DISABLED = 16'h0250;
  localparam logic [15:0] STW_READY       = 16'h0221;
  localparam logic [15:0] STW_ENABLED     = 16'h0237;
  localparam logic [15:0] STW_QSTOP       = 16'h0217;
  localparam logic [15:0] STW_FAULT       = 16'h0208;
  localparam logic [15:0] STW_ENABLED_NEW = 16'h4637;
  localparam logic [15:0] STW_ENABLED_AT  = 16'h0637;
  localparam int STW_REACHED = 10;
  localparam int STW_ZERO    = 12;
  localparam int STW_NO_CMD  = 14;
  localparam int STW_QS_N    = 5;

  typedef enum logic [2:0] {
    ST_DISABLED = 3'b000,
    ST_READY    = 3'b001,
    ST_ENABLED  = 3'b010,
    ST_QSTOP    = 3'b011,
    ST_FAULT    = 3'b100
  } drive_state_e;

  typedef struct packed {
    logic [15:0]        cmd;
    logic signed [31:0] target;
    logic [31:0]        accel;
    logic [31:0]        decel;
    logic [7:0]         mode;
  } rx_pdo_s;

  typedef struct packed {
    logic [15:0] status;
    logic [7:0]  mode;
  } tx_pdo_s;

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction
endpackage

// ### hw/speed_limiter.sv
// Clamps a signed speed to the lower of two magnitude ceilings
`timescale 1ns/100ps
module speed_limiter
  import pv_mode_pkg::*;
(
  input  wire logic signed [31:0] speed_i,
  input  wire logic [31:0]        max_speed_i,
  input  wire logic [31:0]        ramp_ceil_i,
  output logic signed [31:0]      speed_o
);
  wire logic [31:0] ceil_w = (max_speed_i < ramp_ceil_i) ? max_speed_i : ramp_ceil_i;
  wire logic [31:0] mag_w  = mag32(speed_i);
  wire logic        over_w = mag_w > ceil_w;
  wire logic signed [31:0] pos_w = $signed(ceil_w);
  assign speed_o = !over_w ? speed_i : (speed_i[31] ? 32'(-pos_w) : pos_w);
endmodule

// ### hw/speed_ramp.sv
// Velocity ramp generator stepping one RPM at the programmed rate
`timescale 1ns/100ps
module speed_ramp
  import pv_mode_pkg::*;
#(
  parameter int unsigned CLK_RATE_HZ = CLK_HZ
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic signed [31:0] target_i,
  input  wire logic [31:0]        accel_i,
  input  wire logic [31:0]        decel_i,
  output logic signed [31:0]      speed_o
);
  localparam logic [32:0] CLK_W = 33'(CLK_RATE_HZ);
  logic signed [31:0] speed_reg;
  logic signed [31:0] speed_next;
  logic [32:0]        frac_reg;
  logic [32:0]        frac_next;
  wire logic        at_w   = target_i == speed_reg;
  wire logic        up_w   = target_i > speed_reg;
  wire logic        grow_w = (speed_reg == 0) || (up_w != speed_reg[31]);
  wire logic [31:0] rate_w = grow_w ? accel_i : decel_i;
  wire logic [32:0] sum_w  = frac_reg + {1'b0, rate_w};
  wire logic        step_w = !at_w && (sum_w >= CLK_W);
  // Fast rates saturate at one step per clock; residue dropped to keep frac below CLK_W
  assign frac_next  = at_w ? '0 : (!step_w ? sum_w : ({1'b0, rate_w} >= CLK_W) ? '0
                      : 33'(sum_w - CLK_W));
  assign speed_next = !step_w ? speed_reg : (up_w ? 32'(speed_reg + 1) : 32'(speed_reg - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_reg <= '0;
      frac_reg  <= '0;
    end else begin
      speed_reg <= speed_next;
      frac_reg  <= frac_next;
    end
  end
  assign speed_o = speed_reg;
endmodule

// ### test/fieldbus_master_model.sv
// Fieldbus master model: sends one receive image per request
`timescale 1ns/100ps
module fieldbus_master_model
  import pv_mode_pkg::*;
(
  input  wire logic clk_i,
  output logic      pdo_valid_o,
  output rx_pdo_s   rx_pdo_o
);
  // Quick-stop reaction code, declared but never sent to the drive
  localparam int QSTOP_REACT = 6;
  rx_pdo_s img_reg = '0;
  initial pdo_valid_o = 1'b0;
  // Image is only meaningful with the strobe; otherwise show garbage
  assign rx_pdo_o = pdo_valid_o ? img_reg : rx_pdo_s'(~img_reg);

  task automatic send(input logic [15:0] cmd, input logic signed [31:0] tgt,
                      input logic [31:0] acc, input logic [31:0] dec,
                      input logic [7:0] mode);
    @(posedge clk_i);
    #10;
    // Mode-specific command bits are kept clear in this mode
    img_reg = '{cmd: cmd & ~CW_MODE_MASK, target: tgt, accel: acc,
                decel: dec, mode: mode};
    pdo_valid_o = 1'b1;
    @(posedge clk_i);
    #10;
    pdo_valid_o = 1'b0;
  endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the profile-velocity mode control
`timescale 1ns/100ps
module testbench;
  import pv_mode_pkg::*;
  localparam int RATE = 100;
  // Reached bit follows actual against ramp target in every drive state
  localparam logic [15:0] REACHED_BIT = 16'(1 << STW_REACHED);
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               pdo_valid;
  rx_pdo_s            rx_pdo;
  logic signed [31:0] act_speed = '0;
  logic               fault = 1'b0;
  logic [31:0]        max_speed = 32'h0000_1000;
  logic [31:0]        ramp_ceil = 32'h0000_1000;
  logic               par_we = 1'b0;
  logic               par_re = 1'b0;
  logic [15:0]        par_addr = '0;
  logic [31:0]        par_wdata = '0;
  logic [31:0]        par_rdata;
  logic               par_ack;
  tx_pdo_s            tx_pdo;
  logic               tx_valid;
  logic signed [31:0] speed_ref;
  logic               power_en;
  logic [31:0]        rd;
  int                 n;
  int                 fails = 0;
  int                 tests_run = 0;

  always #50 clk = ~clk;
  // Motor follows the reference one cycle late
  always @(posedge clk) act_speed <= rst ? 32'sh0 : speed_ref;

  fieldbus_master_model u_fieldbus_master_model (.clk_i(clk), .pdo_valid_o(pdo_valid),
                                                 .rx_pdo_o(rx_pdo));
  pv_mode_ctrl #(.CLK_RATE_HZ(RATE)) u_pv_mode_ctrl (
    .CORE_CLK_I(clk), .RST_I(rst), .PDO_VALID_I(pdo_valid), .RX_PDO_I(rx_pdo),
    .ACT_SPEED_I(act_speed), .FAULT_I(fault), .MAX_SPEED_I(max_speed),
    .RAMP_CEIL_I(ramp_ceil), .PAR_WE_I(par_we), .PAR_RE_I(par_re), .PAR_ADDR_I(par_addr),
    .PAR_WDATA_I(par_wdata), .PAR_RDATA_O(par_rdata), .PAR_ACK_O(par_ack),
    .TX_PDO_O(tx_pdo), .TX_VALID_O(tx_valid), .SPEED_REF_O(speed_ref), .POWER_EN_O(power_en));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
    #10;
  endtask

  // Accel 50 RPM/s is half a step per clock, decel 100 is one per clock
  task automatic pdo(input logic [15:0] cmd, input logic signed [31:0] tgt,
                     input logic [7:0] mode);
    u_fieldbus_master_model.send(cmd, tgt, 32'd50, 32'd100, mode);
    check(tx_valid, 1'b1);
    wait_cyc(2);
  endtask

  task automatic par(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    #10;
    par_we = wr;
    par_re = !wr;
    par_addr = addr;
    par_wdata = wdata;
    @(posedge clk);
    #10;
    par_we = 1'b0;
    par_re = 1'b0;
    check(par_ack, 1'b1);
    rd = par_rdata;
  endtask

  // Waits for the reference to settle, checking it never jumps
  task automatic settle(input logic signed [31:0] goal);
    logic signed [31:0] prev;
    prev = speed_ref;
    n = 0;
    while (speed_ref !== goal && n < 2000) begin
      wait_cyc(1);
      n++;
      check((speed_ref - prev <= 1) && (prev - speed_ref <= 1), 1'b1);
      prev = speed_ref;
    end
    check(speed_ref, goal);
  endtask

  task automatic t_reset;
    check(tx_pdo.status, STW_SW_DISABLED | REACHED_BIT);
    check(tx_pdo.mode, MODE_RESET);
    check(power_en, 1'b0);
    par(1'b0, REG_TARGET_SPEED, '0);
    check(rd, TARGET_RESET);
    par(1'b1, 16'h1B1C, 32'h0000_0055);
    par(1'b0, 16'h1B1C, '0);
    check(rd, 32'h0);
  endtask

  task automatic t_enable;
    pdo(16'h0000, 0, MODE_RESET);
    pdo(16'h0006, 0, MODE_RESET);
    check(tx_pdo.status, STW_READY | REACHED_BIT);
    pdo(CW_ENABLE, 0, MODE_RESET);
    check(tx_pdo.status, STW_ENABLED_NEW);
    check(power_en, 1'b1);
  endtask

  task automatic t_move;
    pdo(CW_ENABLE, 0, MODE_PROFILE_VEL);
    check(tx_pdo.mode, MODE_PROFILE_VEL);
    check(tx_pdo.status[STW_ZERO], 1'b1);
    par(1'b1, REG_TARGET_SPEED, 32'd20);
    par(1'b0, REG_TARGET_SPEED, '0);
    check(rd, 32'd20);
    wait_cyc(6);
    check(tx_pdo.status[STW_REACHED], 1'b0);
    check(tx_pdo.status[STW_ZERO], 1'b0);
    settle(20);
    check(n >= 25 && n <= 40, 1'b1);
    wait_cyc(3);
    check(tx_pdo.status, STW_ENABLED_AT);
    par(1'b1, REG_TARGET_SPEED, 32'd10);
    settle(10);
    check(n >= 8 && n <= 13, 1'b1);
  endtask

  task automatic t_limits;
    max_speed = 32'd15;
    par(1'b1, REG_TARGET_SPEED, 32'd40);
    settle(15);
    ramp_ceil = 32'd12;
    settle(12);
    max_speed = 32'h0000_1000;
    ramp_ceil = 32'h0000_1000;
    par(1'b1, REG_TARGET_SPEED, -32'sd8);
    settle(-8);
  endtask

  task automatic t_stop;
    pdo(CW_ENABLE, 20, MODE_PROFILE_VEL);
    settle(20);
    pdo(CW_QUICKSTOP, 20, MODE_PROFILE_VEL);
    check(tx_pdo.status[STW_QS_N], 1'b0);
    settle(0);
    pdo(CW_ENABLE, 20, MODE_PROFILE_VEL);
    check(tx_pdo.status[7:0], STW_ENABLED[7:0]);
    check(tx_pdo.status[STW_NO_CMD], 1'b1);
    pdo(CW_ENABLE, 20, MODE_PROFILE_VEL);
    check(tx_pdo.status[STW_NO_CMD], 1'b0);
    settle(20);
    pdo(CW_ENABLE | 16'(1 << CW_HALT), 20, MODE_PROFILE_VEL);
    settle(0);
    pdo(CW_ENABLE, 20, MODE_PROFILE_VEL);
    settle(20);
    pdo(CW_ENABLE, 20, 8'h01);
    check(tx_pdo.mode, MODE_PROFILE_VEL);
    settle(0);
    wait_cyc(3);
    check(tx_pdo.mode, 8'h01);
    fault = 1'b1;
    wait_cyc(3);
    check(tx_pdo.status, STW_FAULT | REACHED_BIT);
    fault = 1'b0;
    pdo(16'h0080, 0, 8'h01);
    check(tx_pdo.status, STW_SW_DISABLED | REACHED_BIT);
  endtask

  task automatic results;
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #10;
    rst = 1'b0;
    wait_cyc(1);
    t_reset();
    t_enable();
    t_move();
    t_limits();
    t_stop();
    results();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    #(100 * 20000);
    fails++;
    results();
  end
endmodule
